// >>> core/timer16_irq_flags_masks.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
//Operation
// - Unit1 capture irq needs enable, global, flag
// - Unit1 compare B irq gated likewise
// - Unit1 compare A irq gated likewise
// - Unit1 overflow irq gated likewise
// - Unit3 four sources gated the same
// - Bits 7:6, 4:3 read zero
// - Capture pin event sets capture flag
// - Capture-as-TOP mode: TOP sets capture flag
// - Compare B flag set tick after match
// - Compare A flag set tick after match
// - Forced compare never sets a flag
// - Overflow flag set per mode event
// - Vector execution clears its flag
// - Writing one clears that flag
module timer16_irq_flags_masks
   import tirq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer tick enables
   input wire logic unit1Tick,
   input wire logic unit3Tick,
   // Unit1 events
   input wire logic unit1_capture_pin,
   input wire logic unit1TopReached,
   input wire logic unit1CmpaMatch,
   input wire logic unit1CmpbMatch,
   input wire logic unit1Overflow,
   // Unit3 events
   input wire logic unit3_capture_pin,
   input wire logic unit3TopReached,
   input wire logic unit3CmpaMatch,
   input wire logic unit3CmpbMatch,
   input wire logic unit3Overflow,
   // Vector acknowledge from CPU, one-hot per flag bit
   input wire logic [7:0] unit1VecAck,
   input wire logic [7:0] unit3VecAck,
   // Requests to CPU
   output logic [7:0] unit1IrqReq,
   output logic [7:0] unit3IrqReq,
   output logic irq
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] mask1;     // timer1_irq_mask
      logic [7:0] mask3;     // timer3_irq_mask
      logic globalEn;        // Global interrupt enable
      logic [2*MODE_W-1:0] modes; // waveform_mode_select per unit
      logic cap1Prev;        // Previous synced pin level
      logic cap3Prev;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [7:0] req1;
      logic [7:0] req3;
      logic irq;
   } top_t;

   top_t st_r, st_nxt;

   // ----------------------------------------
   // Wires
   // ----------------------------------------
   logic cap1Sync, cap3Sync;        // Cleaned capture pins
   logic [7:0] flags1, flags3;       // Current flags
   logic [7:0] swClr1, swClr3;       // Write-one clears
   logic [7:0] vClr1, vClr3;         // Vector clears
   logic setup, access;
   logic [7:0] req1, req3;

   // Interrupt gating for one unit
   function automatic logic [7:0] gateReq(input logic [7:0] m, input logic [7:0] f,
                                          input logic g);
      gateReq = (m & f & IMPL_MASK) & {8{g}};
   endfunction

   // ----------------------------------------
   // Capture pin synchronisers
   // ----------------------------------------
   sync_pin u_sync1 (
      .clk(clk),
      .nrst(nrst),
      .pinIn(unit1_capture_pin),
      .pinOut(cap1Sync)
   );

   sync_pin u_sync3 (
      .clk(clk),
      .nrst(nrst),
      .pinIn(unit3_capture_pin),
      .pinOut(cap3Sync)
   );

   // ----------------------------------------
   // Flag units
   // ----------------------------------------
   unit_flags u_flags1 (
      .clk(clk),
      .nrst(nrst),
      .timerTick(unit1Tick),
      .captureEdge(cap1Sync & ~st_r.cap1Prev),
      .topReached(unit1TopReached),
      .cmpaMatch(unit1CmpaMatch),
      .cmpbMatch(unit1CmpbMatch),
      .overflowEvt(unit1Overflow),
      .waveMode(st_r.modes[MODE_W-1:0]),
      .swClear(swClr1),
      .vecClear(vClr1),
      .flags(flags1)
   );

   unit_flags u_flags3 (
      .clk(clk),
      .nrst(nrst),
      .timerTick(unit3Tick),
      .captureEdge(cap3Sync & ~st_r.cap3Prev),
      .topReached(unit3TopReached),
      .cmpaMatch(unit3CmpaMatch),
      .cmpbMatch(unit3CmpbMatch),
      .overflowEvt(unit3Overflow),
      .waveMode(st_r.modes[U3_MODE_LSB/2+MODE_W-1:U3_MODE_LSB/2]),
      .swClear(swClr3),
      .vecClear(vClr3),
      .flags(flags3)
   );

   // ----------------------------------------
   // Bus decode and clears
   // ----------------------------------------
   always_comb begin
      setup = psel && !penable;
      access = psel && penable && st_r.ready;
      swClr1 = 8'h00;
      swClr3 = 8'h00;
      // Write one to clear flags
      if (access && pwrite && paddr == OFF_T1_FLAGS) begin
         swClr1 = pwdata[7:0] & IMPL_MASK;
      end
      if (access && pwrite && paddr == OFF_T3_FLAGS) begin
         swClr3 = pwdata[7:0] & IMPL_MASK;
      end
      // Vector acknowledges from CPU or register strobe
      vClr1 = unit1VecAck & IMPL_MASK;
      vClr3 = unit3VecAck & IMPL_MASK;
      if (access && pwrite && paddr == OFF_VECTOR) begin
         vClr1 = vClr1 | (pwdata[7:0] & IMPL_MASK);
         vClr3 = vClr3 | (pwdata[15:8] & IMPL_MASK);
      end
      // Requests
      req1 = gateReq(st_r.mask1, flags1, st_r.globalEn);
      req3 = gateReq(st_r.mask3, flags3, st_r.globalEn);
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.cap1Prev = cap1Sync;
      st_nxt.cap3Prev = cap3Sync;
      st_nxt.req1 = req1;
      st_nxt.req3 = req3;
      st_nxt.irq = |{req1, req3};
      // Ready one cycle after setup
      st_nxt.ready = setup;
      st_nxt.err = 1'b0;
      if (setup) begin
         st_nxt.rdata = 32'h0000_0000;
         unique case (paddr)
            OFF_T1_MASK: st_nxt.rdata[7:0] = st_r.mask1;
            OFF_T3_MASK: st_nxt.rdata[7:0] = st_r.mask3;
            OFF_T1_FLAGS: st_nxt.rdata[7:0] = flags1;
            OFF_T3_FLAGS: st_nxt.rdata[7:0] = flags3;
            OFF_GLOBAL: st_nxt.rdata[0] = st_r.globalEn;
            OFF_VECTOR: st_nxt.rdata = 32'h0000_0000;
            OFF_MODE: begin
               st_nxt.rdata[MODE_W-1:0] = st_r.modes[MODE_W-1:0];
               st_nxt.rdata[U3_MODE_LSB+MODE_W-1:U3_MODE_LSB] =
                  st_r.modes[2*MODE_W-1:MODE_W];
            end
            default: st_nxt.err = 1'b1;
         endcase
      end
      // Register writes
      if (access && pwrite) begin
         unique case (paddr)
            OFF_T1_MASK: st_nxt.mask1 = pwdata[7:0] & IMPL_MASK;
            OFF_T3_MASK: st_nxt.mask3 = pwdata[7:0] & IMPL_MASK;
            OFF_GLOBAL: st_nxt.globalEn = pwdata[0];
            OFF_MODE: begin
               st_nxt.modes[MODE_W-1:0] = pwdata[MODE_W-1:0];
               st_nxt.modes[2*MODE_W-1:MODE_W] =
                  pwdata[U3_MODE_LSB+MODE_W-1:U3_MODE_LSB];
            end
            default: ;
         endcase
      end
      // Ready and error pulse end after access
      if (access) begin
         st_nxt.ready = 1'b0;
      end
   end

   // ----------------------------------------
   // Register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flops
   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign unit1IrqReq = st_r.req1;
   assign unit3IrqReq = st_r.req3;
   assign irq = st_r.irq;

endmodule

// >>> pkg/tirq_pkg.sv
package tirq_pkg;

   // ----------------------------------------
   // Register map (word aligned byte offsets)
   // ----------------------------------------
   localparam logic [7:0] OFF_T1_MASK = 8'h00;  // timer1_irq_mask
   localparam logic [7:0] OFF_T3_MASK = 8'h04;  // timer3_irq_mask
   localparam logic [7:0] OFF_T1_FLAGS = 8'h08; // timer1_irq_flags
   localparam logic [7:0] OFF_T3_FLAGS = 8'h0C; // timer3_irq_flags
   localparam logic [7:0] OFF_GLOBAL = 8'h10;   // Global enable, bit 0
   localparam logic [7:0] OFF_VECTOR = 8'h14;   // Vector acknowledge strobe
   localparam logic [7:0] OFF_MODE = 8'h18;     // Mode select, unit1 [3:0], unit3 [11:8]

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_OVF = 0;
   localparam int BIT_CMPA = 1;
   localparam int BIT_CMPB = 2;
   localparam int BIT_CAP = 5;
   localparam logic [7:0] IMPL_MASK = 8'h27;   // Implemented bits 5,2,1,0
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int MODE_W = 4;
   localparam int U3_MODE_LSB = 8;

   // Mode codes, the first four using capture register as TOP
   localparam logic [3:0] MODE_PWM_PF_CAP = 4'h8;
   localparam logic [3:0] MODE_PWM_PC_CAP = 4'hA;
   localparam logic [3:0] MODE_CTC_CAP = 4'hC;
   localparam logic [3:0] MODE_FAST_CAP = 4'hE;
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_A = 4'h4;

endpackage

// >>> core/sync_pin.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser, change taken when stages two and three agree
module sync_pin
   import tirq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pin and clean output
   input wire logic pinIn,
   output logic pinOut
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } sync_t;

   sync_t st_r, st_nxt;

   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pinIn;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // Accept change only when stages agree
      if (st_r.s2 == st_r.s3) begin
         st_nxt.q = st_r.s3;
      end
   end

   // Register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pinOut = st_r.q;

endmodule

// >>> core/unit_flags.sv
`timescale 1ns/10ps
// Flag set/clear logic of one timer unit
module unit_flags
   import tirq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Events from the counter core
   input wire logic timerTick,
   input wire logic captureEdge,
   input wire logic topReached,
   input wire logic cmpaMatch,
   input wire logic cmpbMatch,
   input wire logic overflowEvt,
   input wire logic [MODE_W-1:0] waveMode,
   // Clears
   input wire logic [7:0] swClear,
   input wire logic [7:0] vecClear,
   // Flags
   output logic [7:0] flags
);

   typedef struct packed {
      logic [7:0] flags;
      logic pendA;
      logic pendB;
   } uf_t;

   uf_t st_r, st_nxt;

   // Mode uses capture register as TOP
   function automatic logic capIsTop(input logic [MODE_W-1:0] m);
      capIsTop = (m == MODE_PWM_PF_CAP) || (m == MODE_PWM_PC_CAP) ||
                 (m == MODE_CTC_CAP) || (m == MODE_FAST_CAP);
   endfunction

   logic [7:0] setVec;

   // Next state
   always_comb begin
      st_nxt = st_r;
      setVec = 8'h00;
      // Compare matches seen in one tick set flags on the next tick
      if (timerTick) begin
         setVec[BIT_CMPA] = st_r.pendA;
         setVec[BIT_CMPB] = st_r.pendB;
         st_nxt.pendA = cmpaMatch;      // force strobe is not an input
         st_nxt.pendB = cmpbMatch;
      end
      // Capture source depends on mode
      if (capIsTop(waveMode)) begin
         setVec[BIT_CAP] = topReached;
      end else begin
         setVec[BIT_CAP] = captureEdge;
      end
      // Overflow point given by counter core per mode
      setVec[BIT_OVF] = overflowEvt;
      // Clear on one, set wins, reserved stay zero
      st_nxt.flags = ((st_r.flags & ~(swClear | vecClear)) | setVec)
                     & IMPL_MASK;
   end

   // Register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flags = st_r.flags;

endmodule

// >>> testbench/tirq_chk.sv
`timescale 1ns/10ps
// Protocol and request checks at the top ports
module tirq_chk
   import tirq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Events, vector strobes, requests
   input wire logic unit1Overflow,
   input wire logic [7:0] unit1VecAck,
   input wire logic [7:0] unit1IrqReq,
   input wire logic [7:0] unit3IrqReq,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ----
   // Bus steps
   // ----
   sequence setupS; psel && !penable; endsequence
   sequence accessS; psel && penable && pready; endsequence
   sequence ackS; unit1VecAck[BIT_OVF] && !unit1Overflow; endsequence
   ready_next_a: assert property (setupS |=> accessS)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held");
   err_unmapped_a: assert property (pready && paddr > OFF_MODE |-> pslverr)
      else $error("unmapped not refused");
   read_zero_a: assert property (pready && !pwrite && paddr <= OFF_T3_FLAGS |->
      (prdata & ~{24'h0, IMPL_MASK}) == 32'h0) else $error("reserved bit read one");
   req_impl_a: assert property (((unit1IrqReq | unit3IrqReq) & ~IMPL_MASK) == 8'h00)
      else $error("request on reserved bit");
   irq_level_a: assert property (irq == |{unit1IrqReq, unit3IrqReq})
      else $error("irq not OR of requests");
   reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> !irq && unit1IrqReq == 8'h00)
      else $error("request out of reset");
   vec_clear_a: assert property (ackS |-> ##2 !unit1IrqReq[BIT_OVF])
      else $error("vector left flag set");
endmodule
bind timer16_irq_flags_masks tirq_chk i_chk (.*);

// >>> testbench/cpu_core_model.sv
`timescale 1ns/10ps
// CPU side: runs the vector of the lowest pending unit1 request, else of the lowest pending unit3 request
module cpu_core_model
   import tirq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Dispatch enable and latency
   input wire logic en,
   input wire logic [3:0] lag,
   // Requests in, vector strobes out
   input wire logic [7:0] unit1IrqReq,
   input wire logic [7:0] unit3IrqReq,
   output logic [7:0] unit1VecAck,
   output logic [7:0] unit3VecAck
);
   int cnt;
   // Wait lag+3 cycles so a cleared request has dropped before the next pick
   always @(posedge clk) begin
      unit1VecAck <= 8'h00;
      unit3VecAck <= 8'h00;
      if (!nrst || !en || (unit1IrqReq | unit3IrqReq) == 8'h00) begin
         cnt <= 0;
      end else if (cnt < lag + 3) begin
         cnt <= cnt + 1;
      end else begin
         cnt <= 0;
         if (unit1IrqReq != 8'h00) unit1VecAck <= unit1IrqReq & (~unit1IrqReq + 8'h01);
         else unit3VecAck <= unit3IrqReq & (~unit3IrqReq + 8'h01);
      end
   end
endmodule

// >>> testbench/timer16_irq_flags_masks_tb.sv
`timescale 1ns/10ps
module timer16_irq_flags_masks_tb;
   import tirq_pkg::*;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, cpuEn = 0, err, pready, pslverr, irq;
   logic [7:0] paddr = 8'h00, u1Req, u3Req, u1Ack, u3Ack;
   logic [31:0] pwdata = 32'h0, prdata, rd, rs = 32'h19F7;
   logic [4:0] ev[2] = '{5'h00, 5'h00};
   logic [1:0] tk = 2'h0;
   logic [3:0] lag = 4'h0;
   int fails = 0, samples_checked = 0, m[2], f[2], g = 0, cap = 0;
   always #5 clk = ~clk;
   timer16_irq_flags_masks i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .unit1Tick(tk[0]), .unit3Tick(tk[1]),
      .unit1_capture_pin(ev[0][4]), .unit1TopReached(ev[0][3]), .unit1CmpbMatch(ev[0][2]),
      .unit1CmpaMatch(ev[0][1]), .unit1Overflow(ev[0][0]), .unit3_capture_pin(ev[1][4]),
      .unit3TopReached(ev[1][3]), .unit3CmpbMatch(ev[1][2]), .unit3CmpaMatch(ev[1][1]),
      .unit3Overflow(ev[1][0]), .unit1VecAck(u1Ack), .unit3VecAck(u3Ack),
      .unit1IrqReq(u1Req), .unit3IrqReq(u3Req), .irq(irq));
   cpu_core_model i_cpu (.clk(clk), .nrst(nrst), .en(cpuEn), .lag(lag),
      .unit1IrqReq(u1Req), .unit3IrqReq(u3Req), .unit1VecAck(u1Ack), .unit3VecAck(u3Ack));
   // ----
   // Helpers
   // ----
   function automatic logic [31:0] nx(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Requests against the model
   task automatic chkReq();
      logic [7:0] e1, e3;
      e1 = g ? 8'(f[0] & m[0]) : 8'h00;
      e3 = g ? 8'(f[1] & m[1]) : 8'h00;
      chk(32'({u1Req, u3Req, irq}), 32'({e1, e3, (e1 | e3) != 8'h00}));
   endtask
   // One bus transfer, held until ready
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         chk(32'h0, 32'h1);
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdChk(logic [7:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // Event k: 0 ovf, 1 cmpA, 2 cmpB, 3 top, 4 pin; two ticks for compares
   task automatic fire(int u, int k);
      ev[u][k] <= 1'b1;
      tk[u] <= 1'b1;
      @(posedge clk);
      ev[u][k] <= (k == 4);
      tk[u] <= 1'b0;
      @(posedge clk);
      tk[u] <= 1'b1;
      @(posedge clk);
      tk[u] <= 1'b0;
      repeat (6) @(posedge clk);
      ev[u][4] <= 1'b0;
      @(posedge clk);
      if (k != 3 || cap) f[u] |= (k > 2) ? 32'h20 : (32'h1 << k);
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 4; a++) rdChk(8'(a * 4), 32'h0);
      for (int u = 0; u < 2; u++) begin
         rs = nx(rs);
         m[u] = (rs | 32'h21) & 32'h27;
         apb(1'b1, 8'(u * 4), rs | 32'h21);
         rdChk(8'(u * 4), m[u]);
      end
      apb(1'b1, OFF_GLOBAL, 32'h1);
      g = 1;
      for (int u = 0; u < 2; u++) for (int k = 0; k < 5; k++) begin
         fire(u, k);
         chkReq();
         rdChk(8'(8 + u * 4), f[u]);
      end
      for (int u = 0; u < 2; u++) begin
         rs = nx(rs);
         apb(1'b1, 8'(8 + u * 4), rs);
         f[u] &= ~rs;
         rdChk(8'(8 + u * 4), f[u]);
      end
      apb(1'b1, OFF_GLOBAL, 32'h0);
      g = 0;
      @(posedge clk);
      chkReq();
      apb(1'b1, OFF_GLOBAL, 32'h1);
      g = 1;
      apb(1'b1, OFF_MODE, 32'h0C0C);
      cap = 1;
      for (int u = 0; u < 2; u++) begin
         apb(1'b1, 8'(8 + u * 4), 32'hFF);
         f[u] = 0;
         fire(u, 3);
         rdChk(8'(8 + u * 4), f[u]);
      end
      rs = nx(rs);
      lag <= rs[3:0];
      cpuEn <= 1'b1;
      for (int n = 0; irq !== 1'b0; n++) begin
         if (n > 500) begin
            chk(32'h0, 32'h1);
            stop_test();
         end
         @(posedge clk);
      end
      cpuEn <= 1'b0;
      for (int u = 0; u < 2; u++) begin
         f[u] &= ~m[u];
         rdChk(8'(8 + u * 4), f[u]);
      end
      // Vector strobe register clears only the written flag
      fire(0, 0);
      apb(1'b1, OFF_VECTOR, 32'h1);
      f[0] &= ~32'h1;
      rdChk(OFF_T1_FLAGS, f[0]);
      rdChk(8'h1C, 32'h0);
      chk(32'(err), 32'h1);
      stop_test();
   end
endmodule
